// ===== design/msi_cfg.svh
// Purpose: Constants of the modem status input block
// Assumes: 8-bit register port, 4-bit register address
// Notes:   Definitions only; included by bare name
`ifndef MSI_CFG_SVH
`define MSI_CFG_SVH

// Register port widths
`define MSI_AW 4
`define MSI_DW 8

// Register addresses
`define MSI_ADDR_STAT_A 4'h0
`define MSI_ADDR_STAT_B 4'h1
`define MSI_ADDR_IST    4'h2
`define MSI_ADDR_ICLR   4'h3
`define MSI_ADDR_IEN    4'h4

// Modem status register field positions
`define MSI_BIT_CTS_CHG 0
`define MSI_BIT_DSR_CHG 1
`define MSI_BIT_DCD_CHG 3
`define MSI_BIT_CTS     4
`define MSI_BIT_DSR     5
`define MSI_BIT_DCD     7

// Channels and events
`define MSI_NCH    2
`define MSI_EV_PER 3
`define MSI_EVW    6
`define MSI_EV_CTS 0
`define MSI_EV_DSR 1
`define MSI_EV_DCD 2

// Reset values: modem pins idle high (inactive)
`define MSI_RST_PIN  2'h3
`define MSI_RST_CH   2'h0
`define MSI_RST_EV   6'h00
`define MSI_RST_BYTE 8'h00

`endif

// ===== design/msi_pkg.sv
// Purpose: Types of the modem status input block
// Assumes: Constants come from msi_cfg.svh
// Notes:   Types only
`include "msi_cfg.svh"

package msi_pkg;
  typedef logic [`MSI_DW-1:0]  msi_byte_type;
  typedef logic [`MSI_EVW-1:0] msi_ev_type;
  typedef logic [`MSI_NCH-1:0] msi_ch_type;
  typedef logic [`MSI_AW-1:0]  msi_addr_type;
endpackage

// ===== design/msi_modem_status.sv
// Purpose: Modem status inputs of two serial channels
// Assumes: Modem pins asynchronous, active low
// Notes:   Read data valid one cycle after the read strobe
`include "msi_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////
// How it works
// - Status bit 4 shows inverted clear-to-send
// - Bit 0 flags clear-to-send change since read
// - Clear-to-send never stalls or gates transmission
// - Clear-to-send change interrupts when enabled
// - Status bit 7 shows inverted carrier-detect
// - Bit 3 flags carrier-detect change since read
// - Carrier-detect change interrupts when enabled
// - Each channel keeps its own status state
// - Status bit 5 shows inverted data-set-ready
// - Bit 1 flags data-set-ready change, interrupts
module msi_modem_status (
  input  wire logic                   CORE_CLK,
  input  wire logic                   RST_N,
  input  wire logic [`MSI_NCH-1:0]    CTS_N,
  input  wire logic [`MSI_NCH-1:0]    DSR_N,
  input  wire logic [`MSI_NCH-1:0]    DCD_N,
  input  wire logic [`MSI_AW-1:0]     ADDR,
  input  wire logic [`MSI_DW-1:0]     WDATA,
  input  wire logic                   WR,
  input  wire logic                   RD,
  output var  logic [`MSI_DW-1:0]     RDATA,
  output var  logic                   IRQ
);

  ////////////////////////////////////////////////////////////////////
  // Declarations

  msi_pkg::msi_ch_type   cts_s1_r;
  msi_pkg::msi_ch_type   cts_s2_r;
  msi_pkg::msi_ch_type   cts_prev_r;
  msi_pkg::msi_ch_type   dsr_s1_r;
  msi_pkg::msi_ch_type   dsr_s2_r;
  msi_pkg::msi_ch_type   dsr_prev_r;
  msi_pkg::msi_ch_type   dcd_s1_r;
  msi_pkg::msi_ch_type   dcd_s2_r;
  msi_pkg::msi_ch_type   dcd_prev_r;
  msi_pkg::msi_ch_type   cts_chg;
  msi_pkg::msi_ch_type   dsr_chg;
  msi_pkg::msi_ch_type   dcd_chg;
  msi_pkg::msi_ch_type   clear_to_send_changed_r;
  msi_pkg::msi_ch_type   data_set_ready_changed_r;
  msi_pkg::msi_ch_type   carrier_detect_changed_r;
  msi_pkg::msi_ch_type   stat_rd;
  msi_pkg::msi_ev_type   ev;
  msi_pkg::msi_ev_type   ist_r;
  msi_pkg::msi_ev_type   ist_nxt;
  msi_pkg::msi_ev_type   ien_r;
  msi_pkg::msi_ev_type   clr;
  msi_pkg::msi_byte_type rdata_r;
  logic                  irq_r;

  ////////////////////////////////////////////////////////////////////
  // Helpers

  // Address match, used by every strobe decode
  function automatic logic hit(input msi_pkg::msi_addr_type a,
                               input msi_pkg::msi_addr_type t);
    hit = (a == t);
  endfunction

  // Assemble a modem status register byte; bits 2 and 6 read zero
  function automatic msi_pkg::msi_byte_type stat_byte(
      input logic cts, input logic dsr, input logic dcd,
      input logic cc, input logic dc, input logic kc);
    msi_pkg::msi_byte_type b;
    b = `MSI_RST_BYTE;
    b[`MSI_BIT_CTS]     = ~cts;
    b[`MSI_BIT_DSR]     = ~dsr;
    b[`MSI_BIT_DCD]     = ~dcd;
    b[`MSI_BIT_CTS_CHG] = cc;
    b[`MSI_BIT_DSR_CHG] = dc;
    b[`MSI_BIT_DCD_CHG] = kc;
    stat_byte = b;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers, one set per channel

  // Two flops per pin; reset to the idle high level so no false change
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cts_s1_r <= `MSI_RST_PIN;
      cts_s2_r <= `MSI_RST_PIN;
      dsr_s1_r <= `MSI_RST_PIN;
      dsr_s2_r <= `MSI_RST_PIN;
      dcd_s1_r <= `MSI_RST_PIN;
      dcd_s2_r <= `MSI_RST_PIN;
    end else begin
      cts_s1_r <= CTS_N;
      cts_s2_r <= cts_s1_r;
      dsr_s1_r <= DSR_N;
      dsr_s2_r <= dsr_s1_r;
      dcd_s1_r <= DCD_N;
      dcd_s2_r <= dcd_s1_r;
    end
  end

  // Previous settled level, for change detection off the second flop
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cts_prev_r <= `MSI_RST_PIN;
      dsr_prev_r <= `MSI_RST_PIN;
      dcd_prev_r <= `MSI_RST_PIN;
    end else begin
      cts_prev_r <= cts_s2_r;
      dsr_prev_r <= dsr_s2_r;
      dcd_prev_r <= dcd_s2_r;
    end
  end

  // Either edge counts as a change
  assign cts_chg = cts_s2_r ^ cts_prev_r;
  assign dsr_chg = dsr_s2_r ^ dsr_prev_r;
  assign dcd_chg = dcd_s2_r ^ dcd_prev_r;

  ////////////////////////////////////////////////////////////////////
  // Change flags in the modem status registers

  // Reads of each channel's status register, decoded per channel
  always_comb begin
    stat_rd    = `MSI_RST_CH;
    stat_rd[0] = RD && hit(ADDR, `MSI_ADDR_STAT_A);
    stat_rd[1] = RD && hit(ADDR, `MSI_ADDR_STAT_B);
  end

  // Read clears the flags, but a change in that same cycle wins
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      clear_to_send_changed_r  <= `MSI_RST_CH;
      data_set_ready_changed_r <= `MSI_RST_CH;
      carrier_detect_changed_r <= `MSI_RST_CH;
    end else begin
      for (int ch = 0; ch < `MSI_NCH; ch++) begin
        clear_to_send_changed_r[ch]  <=
          (clear_to_send_changed_r[ch] & ~stat_rd[ch]) | cts_chg[ch];
        data_set_ready_changed_r[ch] <=
          (data_set_ready_changed_r[ch] & ~stat_rd[ch]) | dsr_chg[ch];
        carrier_detect_changed_r[ch] <=
          (carrier_detect_changed_r[ch] & ~stat_rd[ch]) | dcd_chg[ch];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupt status, clear and enable

  // Event vector: three events per channel, channel a in the low bits
  always_comb begin
    ev = `MSI_RST_EV;
    for (int ch = 0; ch < `MSI_NCH; ch++) begin
      ev[ch*`MSI_EV_PER + `MSI_EV_CTS] = cts_chg[ch];
      ev[ch*`MSI_EV_PER + `MSI_EV_DSR] = dsr_chg[ch];
      ev[ch*`MSI_EV_PER + `MSI_EV_DCD] = dcd_chg[ch];
    end
  end

  // Write-one-to-clear; an event in the clearing cycle stays set
  always_comb begin
    clr     = (WR && hit(ADDR, `MSI_ADDR_ICLR)) ? WDATA[`MSI_EVW-1:0] : `MSI_RST_EV;
    ist_nxt = (ist_r & ~clr) | ev;
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ist_r <= `MSI_RST_EV;
    end else begin
      ist_r <= ist_nxt;
    end
  end

  // Enable mask, one bit per event so each channel is gated alone
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ien_r <= `MSI_RST_EV;
    end else if (WR && hit(ADDR, `MSI_ADDR_IEN)) begin
      ien_r <= WDATA[`MSI_EVW-1:0];
    end
  end

  // Level interrupt, registered so the pin is glitch free
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(ist_r & ien_r);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read data

  // Data stand only in the cycle after the strobe, zero otherwise.
  // Clear-to-send reaches only this path and the interrupt, never a transmit gate.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_r <= `MSI_RST_BYTE;
    end else if (RD) begin
      case (ADDR)
        `MSI_ADDR_STAT_A: begin
          rdata_r <= stat_byte(cts_s2_r[0], dsr_s2_r[0], dcd_s2_r[0],
                               clear_to_send_changed_r[0],
                               data_set_ready_changed_r[0],
                               carrier_detect_changed_r[0]);
        end
        `MSI_ADDR_STAT_B: begin
          rdata_r <= stat_byte(cts_s2_r[1], dsr_s2_r[1], dcd_s2_r[1],
                               clear_to_send_changed_r[1],
                               data_set_ready_changed_r[1],
                               carrier_detect_changed_r[1]);
        end
        `MSI_ADDR_IST: begin
          rdata_r <= {2'h0, ist_r};
        end
        `MSI_ADDR_IEN: begin
          rdata_r <= {2'h0, ien_r};
        end
        default: begin
          rdata_r <= `MSI_RST_BYTE;  // Clear register and holes read zero
        end
      endcase
    end else begin
      rdata_r <= `MSI_RST_BYTE;
    end
  end

  assign RDATA = rdata_r;
  assign IRQ   = irq_r;

  ////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  cts_level_a: assert property (
    stat_rd[0] |=> RDATA[`MSI_BIT_CTS] == !$past(cts_s2_r[0]))
    else $error("Status bit 4 is not inverted clear-to-send");

  cts_flag_a: assert property (
    cts_chg[0] |=> clear_to_send_changed_r[0])
    else $error("Clear-to-send change flag not set");

  dcd_level_a: assert property (
    stat_rd[1] |=> RDATA[`MSI_BIT_DCD] == !$past(dcd_s2_r[1]))
    else $error("Status bit 7 is not inverted carrier-detect");

  dcd_flag_a: assert property (
    (carrier_detect_changed_r[1] && stat_rd[1]) |=> RDATA[`MSI_BIT_DCD_CHG])
    else $error("Carrier-detect change not reported on read");

  dsr_level_a: assert property (
    stat_rd[0] |=> RDATA[`MSI_BIT_DSR] == !$past(dsr_s2_r[0]))
    else $error("Status bit 5 is not inverted data-set-ready");

  dsr_irq_a: assert property (
    (dsr_chg[0] && ien_r[`MSI_EV_DSR] && !WR) |-> ##2 IRQ)
    else $error("Data-set-ready change raised no interrupt");

  irq_gate_a: assert property (
    (ist_r & ien_r) == `MSI_RST_EV |=> !IRQ)
    else $error("Interrupt without an enabled status bit");

  read_clear_a: assert property (
    (stat_rd[0] && !cts_chg[0] && !dsr_chg[0] && !dcd_chg[0])
      |=> !clear_to_send_changed_r[0] && !data_set_ready_changed_r[0]
          && !carrier_detect_changed_r[0])
    else $error("Status read did not clear the change flags");

  read_keep_a: assert property (
    (stat_rd[0] && cts_chg[0]) |=> clear_to_send_changed_r[0])
    else $error("Change during status read was lost");

  chan_split_a: assert property (
    (!carrier_detect_changed_r[0] && !dcd_chg[0] && dcd_chg[1])
      |=> !carrier_detect_changed_r[0])
    else $error("Channel b change leaked into channel a");

  dcd_irq_a: assert property (
    (dcd_chg[1] && ien_r[`MSI_EV_PER + `MSI_EV_DCD] && !WR) |-> ##2 IRQ)
    else $error("Carrier-detect change raised no interrupt");

  cts_change_c: cover property (cts_chg[0] ##1 stat_rd[0]);
  irq_raise_c:  cover property (!IRQ ##1 IRQ);
  both_chan_c:  cover property (dcd_chg[0] && dcd_chg[1]);
  read_race_c:  cover property (stat_rd[0] && cts_chg[0]);

endmodule

`default_nettype wire

// ===== verification/msi_modem_model.sv
// Purpose: Modem model driving the modem status pins of both channels
// Assumes: Bench changes the modem state right after a clock edge
// Notes:   Pins are push-pull and always driven, so no released level
`timescale 1ns/1ns
`default_nettype none

module msi_modem_model (
  input  wire logic               [1:0] ready,
  input  wire logic               [1:0] carrier,
  input  wire logic               [1:0] link_up,
  output var  msi_pkg::msi_ch_type      cts_n,
  output var  msi_pkg::msi_ch_type      dcd_n,
  output var  msi_pkg::msi_ch_type      dsr_n
);
  // Active low: an idle modem holds every pin high
  always_comb begin
    cts_n = ~ready;
    dcd_n = ~carrier;
    dsr_n = ~link_up;
  end
endmodule

`default_nettype wire

// ===== verification/tb_msi_modem_status.sv
// Purpose: Self-checking bench of the modem status inputs
// Assumes: Register port answers one cycle after the read strobe
// Notes:   Waits allow the two sync flops plus the flag stage
`include "msi_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module tb_msi_modem_status;
  logic                  core_clk, rst_n, wr, rd, irq, first;
  msi_pkg::msi_addr_type addr;
  msi_pkg::msi_byte_type wdata, rdata, rd_val;
  msi_pkg::msi_ch_type   ready, carrier, link_up, cts_n, dsr_n, dcd_n;
  int                    error_cnt, cmp_count, cyc;

  msi_modem_status msi_modem_status_inst (.CORE_CLK(core_clk), .RST_N(rst_n),
    .CTS_N(cts_n), .DSR_N(dsr_n), .DCD_N(dcd_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq));
  msi_modem_model msi_modem_model_inst (.ready(ready), .carrier(carrier),
    .link_up(link_up), .cts_n(cts_n), .dcd_n(dcd_n), .dsr_n(dsr_n));

  ////////////////////////////////////////////////////////////////////
  // Clock and hang guard; whole run needs well under 400 cycles
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      error_cnt = error_cnt + 1;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("errors %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk8(input string what, input msi_pkg::msi_byte_type exp,
                      input msi_pkg::msi_byte_type got);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask
  // Bus cycles: one-cycle strobes, read data taken in the following cycle
  task automatic reg_wr(input msi_pkg::msi_addr_type a, input msi_pkg::msi_byte_type d);
    @(posedge core_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input msi_pkg::msi_addr_type a);
    @(posedge core_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 rd_val = rdata;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_idle();
    reg_rd(`MSI_ADDR_STAT_A);
    chk8("status a", 8'h00, rd_val);
    reg_rd(`MSI_ADDR_IST);
    chk8("int status", 8'h00, rd_val);
    chk1("irq", 1'b0, irq);
  endtask
  task automatic t_cts_a();
    @(posedge core_clk) ready <= 2'b01;
    wait_cyc(5);
    reg_rd(`MSI_ADDR_STAT_A);
    chk8("status a", 8'h11, rd_val);
    reg_rd(`MSI_ADDR_STAT_A);
    chk8("status a reread", 8'h10, rd_val);
    reg_rd(`MSI_ADDR_STAT_B);
    chk8("status b", 8'h00, rd_val);
    reg_rd(`MSI_ADDR_IST);
    chk8("int status", 8'h01, rd_val);
    chk1("irq masked", 1'b0, irq);
    reg_wr(`MSI_ADDR_IEN, 8'h01);
    wait_cyc(2);
    chk1("irq enabled", 1'b1, irq);
    reg_wr(`MSI_ADDR_ICLR, 8'h01);
    wait_cyc(2);
    chk1("irq cleared", 1'b0, irq);
  endtask
  task automatic t_dcd_b();
    reg_wr(`MSI_ADDR_IEN, 8'h20);
    @(posedge core_clk) carrier <= 2'b10;
    wait_cyc(6);
    chk1("irq dcd b", 1'b1, irq);
    reg_rd(`MSI_ADDR_STAT_B);
    chk8("status b", 8'h88, rd_val);
    reg_rd(`MSI_ADDR_IST);
    chk8("int status", 8'h20, rd_val);
    reg_wr(`MSI_ADDR_ICLR, 8'h20);
    wait_cyc(2);
    chk1("irq cleared", 1'b0, irq);
  endtask
  task automatic t_dsr_a();
    reg_wr(`MSI_ADDR_IEN, 8'h02);
    @(posedge core_clk) link_up <= 2'b01;
    wait_cyc(6);
    chk1("irq dsr a", 1'b1, irq);
    reg_rd(`MSI_ADDR_STAT_A);
    chk8("status a", 8'h32, rd_val);
    reg_wr(`MSI_ADDR_IEN, 8'h00);
    wait_cyc(2);
    chk1("irq disabled", 1'b0, irq);
    reg_wr(`MSI_ADDR_ICLR, 8'h3F);
  endtask
  // Unmapped and write-only places read zero; stray write has no effect
  task automatic t_regs();
    reg_wr(`MSI_ADDR_IEN, 8'h3F);
    reg_rd(`MSI_ADDR_IEN);
    chk8("int enable", 8'h3F, rd_val);
    reg_rd(`MSI_ADDR_ICLR);
    chk8("int clear", 8'h00, rd_val);
    reg_wr(4'hF, 8'hFF);
    reg_rd(4'hF);
    chk8("unmapped", 8'h00, rd_val);
    reg_rd(`MSI_ADDR_IST);
    chk8("int status", 8'h00, rd_val);
  endtask
  // Pin rises so its flag lands at the very edge that takes a read
  task automatic t_read_race();
    @(posedge core_clk) ready <= 2'b00;
    wait_cyc(1);
    reg_rd(`MSI_ADDR_STAT_A);
    first = rd_val[0];
    reg_rd(`MSI_ADDR_STAT_A);
    chk1("change kept", 1'b1, first | rd_val[0]);
    reg_rd(`MSI_ADDR_STAT_A);
    chk8("status a", 8'h20, rd_val);
  endtask

  ////////////////////////////////////////////////////////////////////
  // Main sequence: inputs idle at time zero, reset two cycles
  initial begin
    error_cnt = 0;
    cmp_count = 0;
    cyc = 0;
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    ready = 2'b00;
    carrier = 2'b00;
    link_up = 2'b00;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    t_idle();
    t_cts_a();
    t_dcd_b();
    t_dsr_a();
    t_regs();
    t_read_race();
    final_report();
  end
endmodule

`default_nettype wire
